// ### swd_pkg.sv
package swd_pkg;

    localparam int CLK_HZ = 50000000;
    localparam int MS_CYCLES_DEF = CLK_HZ / 1000;
    localparam int RESET_HOLD_US = 1000;
    localparam int RESET_HOLD_CYCLES_DEF = RESET_HOLD_US * (CLK_HZ / 1000000);

    localparam logic [6:0] ADDR_WD_CTRL = 7'h00;
    localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
    localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;
    localparam logic [6:0] ADDR_WD_STATUS = 7'h05;

    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_PHASE_BITS = 5'h08;

    localparam int WMC_LSB = 5;
    localparam int OTW_BIT = 6;
    localparam int NMS_BIT = 5;
    localparam int FNM_BIT = 3;
    localparam int SDM_BIT = 2;

    localparam logic [2:0] MC_SLEEP = 3'h1;
    localparam logic [2:0] MC_STANDBY = 3'h4;
    localparam logic [2:0] MC_NORMAL = 3'h7;

    localparam logic [2:0] WMC_AUTO = 3'h1;
    localparam logic [2:0] WMC_TIMEOUT = 3'h2;
    localparam logic [2:0] WMC_WINDOW = 3'h4;

    localparam logic [3:0] NWP_8 = 4'h8;
    localparam logic [3:0] NWP_16 = 4'h1;
    localparam logic [3:0] NWP_32 = 4'h2;
    localparam logic [3:0] NWP_64 = 4'hB;
    localparam logic [3:0] NWP_128 = 4'h4;
    localparam logic [3:0] NWP_256 = 4'hD;
    localparam logic [3:0] NWP_1024 = 4'hE;
    localparam logic [3:0] NWP_4096 = 4'h7;
    localparam logic [3:0] NWP_RESET = NWP_128;

    localparam logic [4:0] RSS_POWER_ON = 5'h00;
    localparam logic [4:0] RSS_WD_SLEEP = 5'h0C;
    localparam logic [4:0] RSS_WD_EARLY = 5'h0E;
    localparam logic [4:0] RSS_WD_OVERFLOW = 5'h0F;
    localparam logic [4:0] RSS_ILLEGAL_WMC = 5'h10;

    localparam logic [1:0] WDS_OFF = 2'h0;
    localparam logic [1:0] WDS_FIRST = 2'h1;
    localparam logic [1:0] WDS_SECOND = 2'h2;

    typedef enum logic [2:0] {
        CHIP_STANDBY,
        CHIP_NORMAL,
        CHIP_SLEEP,
        CHIP_RESET,
        CHIP_FORCED
    } swd_chip_type;

    typedef enum logic [1:0] {
        WD_OFF,
        WD_TIMEOUT,
        WD_WINDOW
    } swd_wdrun_type;

endpackage

// ### swd_watchdog_mode_control.sv
`timescale 1ns/10ps
`default_nettype none

module swd_watchdog_mode_control #(
    parameter int MS_CYCLES = swd_pkg::MS_CYCLES_DEF,
    parameter int RESET_HOLD_CYCLES = swd_pkg::RESET_HOLD_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    input wire logic overtempWarn,
    input wire logic forcedNormalCfg,
    input wire logic swDevCfg,
    input wire logic irqOutNPrimary,
    input wire logic wdogIrqClear,
    input wire logic resetReq,
    input wire logic [4:0] resetReqCode,
    output logic resetOutN,
    output logic wdogIrqFlag,
    output logic spiFailIrq
);

    logic [2:0] sclkSync;
    logic [1:0] csnSync;
    logic [1:0] mosiSync;
    logic [1:0] otwSync;
    logic [1:0] fnmSync;
    logic [1:0] sdmSync;
    logic csnPrev;

    logic [15:0] rxShift;
    logic [7:0] txShift;
    logic [4:0] bitCount;

    swd_pkg::swd_chip_type chip;
    swd_pkg::swd_chip_type nextChip;
    swd_pkg::swd_wdrun_type wdRun;
    swd_pkg::swd_wdrun_type wdRunPrev;
    logic [2:0] wdogModeSel;
    logic [3:0] wdogPeriodSel;
    logic normalEnteredFlag;
    logic [4:0] resetSourceCode;
    logic [15:0] msPrescale;
    logic [12:0] msCount;
    logic [19:0] holdCount;
    logic [1:0] strapWait;

    // Oscillator stand-in: one-millisecond tick from the system clock
    // Illegal codes map to zero, so the decode doubles as validity check
    function automatic logic [12:0] periodMs(input logic [3:0] code);
        unique case (code)
            swd_pkg::NWP_8: periodMs = 13'h0008;
            swd_pkg::NWP_16: periodMs = 13'h0010;
            swd_pkg::NWP_32: periodMs = 13'h0020;
            swd_pkg::NWP_64: periodMs = 13'h0040;
            swd_pkg::NWP_128: periodMs = 13'h0080;
            swd_pkg::NWP_256: periodMs = 13'h0100;
            swd_pkg::NWP_1024: periodMs = 13'h0400;
            swd_pkg::NWP_4096: periodMs = 13'h1000;
            default: periodMs = 13'h0000;
        endcase
    endfunction

    // Link sampling
    wire sclkRise = sclkSync[1] & ~sclkSync[2];
    wire sclkFall = ~sclkSync[1] & sclkSync[2];
    wire csnLow = ~csnSync[1];
    wire csnRise = csnSync[1] & ~csnPrev;
    wire frameDone = csnRise && (bitCount == swd_pkg::FRAME_BITS);
    wire [6:0] rxAddr = rxShift[15:9];
    wire rxReadOnly = rxShift[8];
    wire [7:0] rxData = rxShift[7:0];
    wire [6:0] liveAddr = rxShift[6:0];

    // SPI writes are dropped in Sleep, Reset and forced normal; reads are answered in every mode
    // Limitation: a write landing in Reset or Sleep is lost, not queued
    wire spiOpen = (chip == swd_pkg::CHIP_STANDBY) || (chip == swd_pkg::CHIP_NORMAL);
    wire wrValid = frameDone && !rxReadOnly && spiOpen;

    // Watchdog control write decode
    wire [2:0] newWmc = rxData[swd_pkg::WMC_LSB +: 3];
    wire [3:0] newNwp = rxData[3:0];
    wire wmcOk = (newWmc == swd_pkg::WMC_AUTO) || (newWmc == swd_pkg::WMC_TIMEOUT)
        || (newWmc == swd_pkg::WMC_WINDOW);
    wire nwpOk = periodMs(newNwp) != 13'h0000;
    wire wrWd = wrValid && (rxAddr == swd_pkg::ADDR_WD_CTRL);
    wire wdGood = wrWd && wmcOk && nwpOk;
    wire wdBad = wrWd && !(wmcOk && nwpOk);
    wire illegalWmc = wdGood && (chip == swd_pkg::CHIP_NORMAL) && (newWmc != wdogModeSel);
    wire wdLoad = wdGood && (chip == swd_pkg::CHIP_STANDBY);

    // Operating mode write decode
    wire wrMode = wrValid && (rxAddr == swd_pkg::ADDR_MODE_CTRL);
    wire [2:0] newMc = rxData[2:0];
    wire goSleep = wrMode && (newMc == swd_pkg::MC_SLEEP);
    wire goStandby = wrMode && (newMc == swd_pkg::MC_STANDBY);
    wire goNormal = wrMode && (newMc == swd_pkg::MC_NORMAL);

    // Watchdog timing
    wire [12:0] curPeriod = periodMs(wdogPeriodSel);
    wire [12:0] halfPeriod = {1'b0, curPeriod[12:1]};
    wire msTick = msPrescale == 16'(MS_CYCLES - 1);
    wire firstHalf = msCount < halfPeriod;
    wire wdOverflow = (wdRun != swd_pkg::WD_OFF) && msTick && (msCount == curPeriod - 13'h0001);
    wire toOverflow = wdOverflow && (wdRun == swd_pkg::WD_TIMEOUT);
    wire earlyTrig = wdGood && (wdRun == swd_pkg::WD_WINDOW) && firstHalf;
    wire winOverflow = wdOverflow && (wdRun == swd_pkg::WD_WINDOW);
    wire sleepWake = toOverflow && (chip == swd_pkg::CHIP_SLEEP);
    wire toReset = toOverflow && wdogIrqFlag && !sleepWake;
    wire toFlagSet = toOverflow && !toReset && !sleepWake;
    wire wdRestart = wdGood || wdOverflow || (wdRun != wdRunPrev);

    wire extReset = resetReq && (chip != swd_pkg::CHIP_RESET);
    wire doReset = illegalWmc || earlyTrig || winOverflow || toReset || sleepWake || extReset;
    wire holdDone = holdCount == 20'(RESET_HOLD_CYCLES - 1);
    // Single strobe on entry, so cause and defaults are caught once
    wire enterReset = (nextChip == swd_pkg::CHIP_RESET) && (chip != swd_pkg::CHIP_RESET);

    logic [4:0] resetCause;
    always_comb begin
        if (illegalWmc) begin
            resetCause = swd_pkg::RSS_ILLEGAL_WMC;
        end else if (earlyTrig) begin
            resetCause = swd_pkg::RSS_WD_EARLY;
        end else if (winOverflow || toReset) begin
            resetCause = swd_pkg::RSS_WD_OVERFLOW;
        end else if (sleepWake) begin
            resetCause = swd_pkg::RSS_WD_SLEEP;
        end else begin
            resetCause = resetReqCode;
        end
    end

    // Effective watchdog behaviour per chip mode
    always_comb begin
        wdRun = swd_pkg::WD_OFF;
        unique case (chip)
            swd_pkg::CHIP_NORMAL: begin
                if (wdogModeSel == swd_pkg::WMC_WINDOW) begin
                    wdRun = swd_pkg::WD_WINDOW;
                end else if (wdogModeSel == swd_pkg::WMC_TIMEOUT || !sdmSync[1]) begin
                    wdRun = swd_pkg::WD_TIMEOUT;
                end
            end
            swd_pkg::CHIP_STANDBY: begin
                if (wdogModeSel != swd_pkg::WMC_AUTO) begin
                    wdRun = swd_pkg::WD_TIMEOUT;
                end else if (!sdmSync[1] && !irqOutNPrimary) begin
                    wdRun = swd_pkg::WD_TIMEOUT;
                end
            end
            swd_pkg::CHIP_SLEEP: begin
                if (wdogModeSel != swd_pkg::WMC_AUTO) begin
                    wdRun = swd_pkg::WD_TIMEOUT;
                end
            end
            swd_pkg::CHIP_RESET, swd_pkg::CHIP_FORCED: begin
                wdRun = swd_pkg::WD_OFF;
            end
        endcase
    end

    // Forced normal overrides every request; leaving it lands in Standby
    always_comb begin
        nextChip = chip;
        if (chip == swd_pkg::CHIP_RESET) begin
            if (holdDone) begin
                nextChip = swd_pkg::CHIP_STANDBY;
            end
        end else if (fnmSync[1]) begin
            nextChip = swd_pkg::CHIP_FORCED;
        end else if (chip == swd_pkg::CHIP_FORCED) begin
            nextChip = swd_pkg::CHIP_STANDBY;
        end else if (doReset) begin
            nextChip = swd_pkg::CHIP_RESET;
        end else if (goSleep) begin
            nextChip = swd_pkg::CHIP_SLEEP;
        end else if (goStandby) begin
            nextChip = swd_pkg::CHIP_STANDBY;
        end else if (goNormal) begin
            nextChip = swd_pkg::CHIP_NORMAL;
        end
    end

    // Read data, picked once the address byte is in
    // Forced normal reads back as Normal, the closest legal code
    wire [2:0] mcRead = (chip == swd_pkg::CHIP_NORMAL || chip == swd_pkg::CHIP_FORCED) ? swd_pkg::MC_NORMAL :
        (chip == swd_pkg::CHIP_SLEEP) ? swd_pkg::MC_SLEEP : swd_pkg::MC_STANDBY;
    wire [1:0] wdsRead = (wdRun == swd_pkg::WD_OFF) ? swd_pkg::WDS_OFF :
        (firstHalf ? swd_pkg::WDS_FIRST : swd_pkg::WDS_SECOND);
    wire [7:0] mainStatus = {1'b0, otwSync[1], normalEnteredFlag, resetSourceCode};
    wire [7:0] wdStatus = {4'h0, fnmSync[1], sdmSync[1], wdsRead};
    // Unmapped addresses read as zero
    wire selWdCtrl = liveAddr == swd_pkg::ADDR_WD_CTRL;
    wire selModeCtrl = liveAddr == swd_pkg::ADDR_MODE_CTRL;
    wire selMainStatus = liveAddr == swd_pkg::ADDR_MAIN_STATUS;
    wire selWdStatus = liveAddr == swd_pkg::ADDR_WD_STATUS;
    wire [7:0] readData = selWdCtrl ? {wdogModeSel, 1'b0, wdogPeriodSel} :
        selModeCtrl ? {5'h00, mcRead} :
        selMainStatus ? mainStatus :
        selWdStatus ? wdStatus : 8'h00;

    // Two flops on the SPI, overtemp and strap inputs; third sclk stage only for edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclkSync <= 3'h0;
            csnSync <= 2'h3;
            csnPrev <= 1'b1;
            mosiSync <= 2'h0;
            otwSync <= 2'h0;
            fnmSync <= 2'h0;
            sdmSync <= 2'h0;
        end else begin
            sclkSync <= {sclkSync[1:0], spiSclk};
            csnSync <= {csnSync[0], spiCsN};
            csnPrev <= csnSync[1];
            mosiSync <= {mosiSync[0], spiMosi};
            otwSync <= {otwSync[0], overtempWarn};
            fnmSync <= {fnmSync[0], forcedNormalCfg};
            sdmSync <= {sdmSync[0], swDevCfg};
        end
    end

    // Frame shifter: MSB first, address, read-only bit, data
    always_ff @(posedge clk_sys) begin
        if (rst || !csnLow) begin
            rxShift <= 16'h0000;
            bitCount <= 5'h00;
        end else if (sclkRise) begin
            rxShift <= {rxShift[14:0], mosiSync[1]};
            bitCount <= (bitCount == 5'h1F) ? bitCount : bitCount + 5'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txShift <= 8'h00;
            spiMiso <= 1'b0;
            spiMisoOe <= 1'b0;
        end else begin
            spiMisoOe <= csnLow;
            if (!csnLow) begin
                spiMiso <= 1'b0;
            end else if (sclkRise && bitCount == (swd_pkg::ADDR_PHASE_BITS - 5'h01)) begin
                txShift <= readData;
            end else if (sclkFall && bitCount >= swd_pkg::ADDR_PHASE_BITS) begin
                spiMiso <= txShift[7];
                txShift <= {txShift[6:0], 1'b0};
            end
        end
    end
    // Byte loads at the eighth rise, ahead of the eighth falling edge

    // A bad code drops the whole write, registers untouched
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spiFailIrq <= 1'b0;
        end else begin
            spiFailIrq <= wdBad;
        end
    end

    // Reset and Sleep both hold the reset pin low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chip <= swd_pkg::CHIP_STANDBY;
            holdCount <= 20'h00000;
            resetOutN <= 1'b0;
        end else begin
            chip <= nextChip;
            holdCount <= (chip == swd_pkg::CHIP_RESET && !holdDone) ? holdCount + 20'h00001 : 20'h00000;
            resetOutN <= (nextChip != swd_pkg::CHIP_RESET) && (nextChip != swd_pkg::CHIP_SLEEP);
        end
    end

    // Flag survives watchdog resets; only power-on sets it again
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            normalEnteredFlag <= 1'b1;
            resetSourceCode <= swd_pkg::RSS_POWER_ON;
        end else begin
            if (chip == swd_pkg::CHIP_NORMAL) begin
                normalEnteredFlag <= 1'b0;
            end
            if (enterReset) begin
                resetSourceCode <= resetCause;
            end
        end
    end

    // Sw-dev strap is only trusted once its synchroniser has filled
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strapWait <= 2'h0;
            wdogModeSel <= swd_pkg::WMC_TIMEOUT;
            wdogPeriodSel <= swd_pkg::NWP_RESET;
        end else begin
            strapWait <= (strapWait == 2'h3) ? strapWait : strapWait + 2'h1;
            if ((strapWait == 2'h2) || enterReset) begin
                wdogModeSel <= sdmSync[1] ? swd_pkg::WMC_AUTO : swd_pkg::WMC_TIMEOUT;
                wdogPeriodSel <= swd_pkg::NWP_RESET;
            end else if (wdLoad) begin
                wdogModeSel <= newWmc;
                wdogPeriodSel <= newNwp;
            end
        end
    end

    // Prescaler restarts with the timer, so a trigger sees a whole period
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdRunPrev <= swd_pkg::WD_OFF;
            msPrescale <= 16'h0000;
            msCount <= 13'h0000;
        end else begin
            wdRunPrev <= wdRun;
            if (wdRun == swd_pkg::WD_OFF || wdRestart) begin
                msPrescale <= 16'h0000;
                msCount <= 13'h0000;
            end else if (msTick) begin
                msPrescale <= 16'h0000;
                msCount <= msCount + 13'h0001;
            end else begin
                msPrescale <= msPrescale + 16'h0001;
            end
        end
    end

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdogIrqFlag <= 1'b0;
        end else if (toFlagSet) begin
            wdogIrqFlag <= 1'b1;
        end else if (wdogIrqClear) begin
            wdogIrqFlag <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### swd_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module swd_assertions #(
    parameter int MS_CYCLES = 4,
    parameter int RESET_HOLD_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spiCsN,
    input wire logic spiMisoOe,
    input wire logic forcedNormalCfg,
    input wire logic wdogIrqClear,
    input wire logic resetReq,
    input wire logic resetOutN,
    input wire logic wdogIrqFlag,
    input wire logic spiFailIrq
);
    int lowCnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence csLow4;
        !spiCsN [*4];
    endsequence
    sequence forcedHeld;
        forcedNormalCfg [*8];
    endsequence
    // Saturates so a long Sleep cannot wrap it
    always_ff @(posedge clk_sys) begin
        if (rst || resetOutN) begin
            lowCnt <= 0;
        end else if (lowCnt < 65536) begin
            lowCnt <= lowCnt + 1;
        end
    end
    rst_quiet_a: assert property (disable iff (1'b0) rst |=> !resetOutN && !spiMisoOe && !wdogIrqFlag && !spiFailIrq)
        else $error("outputs active during reset");
    reset_exit_a: assert property ($fell(rst) |=> resetOutN)
        else $error("no standby after reset release");
    fail_pulse_a: assert property (spiFailIrq |=> !spiFailIrq)
        else $error("failure pulse too long");
    fail_cause_a: assert property (spiFailIrq |-> $past(spiCsN) && $past(spiCsN, 2))
        else $error("failure pulse without frame end");
    flag_set_a: assert property ($rose(wdogIrqFlag) |-> $past(resetOutN))
        else $error("flag set outside running state");
    flag_hold_a: assert property ($fell(wdogIrqFlag) |-> $past(wdogIrqClear) || !$past(resetOutN) || !resetOutN)
        else $error("flag dropped without clear");
    req_reset_a: assert property (resetReq && !forcedNormalCfg |-> ##[1:3] !resetOutN)
        else $error("reset request ignored");
    forced_off_a: assert property (forcedHeld |-> !$rose(wdogIrqFlag))
        else $error("watchdog ran in forced normal");
    oe_follow_a: assert property (csLow4 |-> spiMisoOe)
        else $error("miso not enabled while selected");
    hold_len_a: assert property ($rose(resetOutN) && !$past(rst, 2) |-> lowCnt >= RESET_HOLD_CYCLES - 2)
        else $error("reset pulse too short");
endmodule
bind swd_watchdog_mode_control swd_assertions #(.MS_CYCLES(MS_CYCLES), .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) chk_u (
    .clk_sys(clk_sys), .rst(rst), .spiCsN(spiCsN), .spiMisoOe(spiMisoOe), .forcedNormalCfg(forcedNormalCfg),
    .wdogIrqClear(wdogIrqClear), .resetReq(resetReq), .resetOutN(resetOutN), .wdogIrqFlag(wdogIrqFlag),
    .spiFailIrq(spiFailIrq));
`default_nettype wire

// ### swd_spi_host.sv
`timescale 1ns/10ps
`default_nettype none
module swd_spi_host (
    output logic spiSclk,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso,
    input wire logic spiMisoOe
);
    initial begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
    // Sclk stands still between frames
    task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] d, input int nb,
        output logic [7:0] q);
        logic [15:0] f;
        f = {a, r, d};
        q = 8'h00;
        spiCsN = 1'b0;
        for (int i = 0; i < nb; i++) begin
            spiMosi = f[15 - i];
            #80;
            spiSclk = 1'b1;
            if (i > 7) q = {q[6:0], spiMisoOe ? spiMiso : 1'bx};
            #80;
            spiSclk = 1'b0;
        end
        #80;
        spiCsN = 1'b1;
        // Released line shows the inverse, never a stale copy
        spiMosi = ~spiMosi;
        #200;
    endtask
endmodule
`default_nettype wire

// ### swd_watchdog_mode_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module swd_watchdog_mode_control_tb_top;
    localparam logic [3:0] NWP_ALL [8] = '{swd_pkg::NWP_8, swd_pkg::NWP_16, swd_pkg::NWP_32, swd_pkg::NWP_64,
        swd_pkg::NWP_128, swd_pkg::NWP_256, swd_pkg::NWP_1024, swd_pkg::NWP_4096};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe, resetOutN, wdogIrqFlag, spiFailIrq;
    logic overtempWarn = 1'b0;
    logic forcedNormalCfg = 1'b0;
    logic swDevCfg = 1'b0;
    logic irqOutNPrimary = 1'b1;
    logic wdogIrqClear = 1'b0;
    logic resetReq = 1'b0;
    logic [4:0] resetReqCode = 5'h00;
    logic [31:0] seed = 32'h2ACE;
    logic [7:0] q, cur;
    logic [2:0] w;
    logic [3:0] p;
    logic ok;
    int err_count = 0;
    int checked = 0;
    int failSeen = 0;
    int n;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (spiFailIrq === 1'b1) failSeen++;
    swd_watchdog_mode_control #(.MS_CYCLES(4), .RESET_HOLD_CYCLES(8)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe), .overtempWarn(overtempWarn), .forcedNormalCfg(forcedNormalCfg), .swDevCfg(swDevCfg),
        .irqOutNPrimary(irqOutNPrimary), .wdogIrqClear(wdogIrqClear), .resetReq(resetReq),
        .resetReqCode(resetReqCode), .resetOutN(resetOutN), .wdogIrqFlag(wdogIrqFlag), .spiFailIrq(spiFailIrq));
    swd_spi_host host_u (.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] wc(input logic [2:0] m, input logic [3:0] pc);
        return {m, 1'b0, pc};
    endfunction
    function automatic logic [7:0] st(input logic normal_entered_flag, input logic [4:0] rs);
        return {1'b0, overtempWarn, normal_entered_flag, rs};
    endfunction
    function automatic logic validNwp(input logic [3:0] pc);
        validNwp = 1'b0;
        foreach (NWP_ALL[i]) if (NWP_ALL[i] == pc) validNwp = 1'b1;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer(a, 1'b0, d, 16, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
        host_u.xfer(a, 1'b1, 8'h00, 16, q);
        chk("register", q & m, e);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    // Bounded wait; a hang ends the run at once
    task automatic waitFor(input logic sel, input logic v, input int lim);
        int k;
        k = 0;
        while ((sel ? wdogIrqFlag : resetOutN) !== v && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
        chk(sel ? "flag" : "resetOutN", sel ? wdogIrqFlag : resetOutN, v);
        if (k >= lim) tally_and_finish();
    endtask
    task automatic pulse(input logic clr);
        @(negedge clk_sys);
        if (clr) wdogIrqClear = 1'b1;
        else resetReq = 1'b1;
        @(negedge clk_sys);
        wdogIrqClear = 1'b0;
        resetReq = 1'b0;
    endtask
    // Through a reset; a pending flag would turn the next overflow into a reset
    task automatic bounce(input int lim);
        waitFor(1'b0, 1'b0, lim);
        waitFor(1'b0, 1'b1, lim);
        pulse(1'b1);
    endtask
    initial begin
        #1000000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        seed = lfsr(seed);
        overtempWarn = seed[0];
        cyc(20);
        rst = 1'b0;
        cyc(5);
        rd(swd_pkg::ADDR_WD_CTRL, 8'hFF, wc(swd_pkg::WMC_TIMEOUT, swd_pkg::NWP_RESET));
        rd(swd_pkg::ADDR_MAIN_STATUS, 8'hFF, st(1'b1, swd_pkg::RSS_POWER_ON));
        rd(swd_pkg::ADDR_MODE_CTRL, 8'hFF, {5'h00, swd_pkg::MC_STANDBY});
        rd(swd_pkg::ADDR_WD_STATUS, 8'hFC, 8'h00);
        rd(7'h02, 8'hFF, 8'h00);
        foreach (NWP_ALL[i]) begin
            wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_AUTO, NWP_ALL[i]));
            rd(swd_pkg::ADDR_WD_CTRL, 8'hFF, wc(swd_pkg::WMC_AUTO, NWP_ALL[i]));
        end
        pulse(1'b1);
        cur = wc(swd_pkg::WMC_AUTO, swd_pkg::NWP_4096);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            w = (i == 0) ? 3'h3 : seed[2:0];
            p = (i == 1) ? 4'h9 : seed[6:3];
            // Only Autonomous stays off here, so short periods cannot fire
            if (w == swd_pkg::WMC_TIMEOUT || w == swd_pkg::WMC_WINDOW) w = swd_pkg::WMC_AUTO;
            ok = (w == swd_pkg::WMC_AUTO) && validNwp(p);
            n = failSeen;
            wr(swd_pkg::ADDR_WD_CTRL, wc(w, p));
            if (ok) cur = wc(w, p);
            cyc(2);
            chk("failIrq", 8'(failSeen - n), ok ? 8'h00 : 8'h01);
            rd(swd_pkg::ADDR_WD_CTRL, 8'hFF, cur);
        end
        host_u.xfer(swd_pkg::ADDR_WD_CTRL, 1'b0, wc(swd_pkg::WMC_AUTO, swd_pkg::NWP_8), 12, q);
        rd(swd_pkg::ADDR_WD_CTRL, 8'hFF, cur);
        wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_AUTO, swd_pkg::NWP_8));
        cyc(100);
        chk("flag", wdogIrqFlag, 1'b0);
        irqOutNPrimary = 1'b0;
        waitFor(1'b1, 1'b1, 100);
        irqOutNPrimary = 1'b1;
        pulse(1'b1);
        cyc(2);
        chk("flag", wdogIrqFlag, 1'b0);
        forcedNormalCfg = 1'b1;
        irqOutNPrimary = 1'b0;
        cyc(100);
        chk("flag", wdogIrqFlag, 1'b0);
        rd(swd_pkg::ADDR_WD_STATUS, 8'h0C, 8'h08);
        @(negedge clk_sys);
        forcedNormalCfg = 1'b0;
        irqOutNPrimary = 1'b1;
        cyc(10);
        wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_TIMEOUT, swd_pkg::NWP_128));
        cyc(300);
        wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_TIMEOUT, swd_pkg::NWP_128));
        cyc(300);
        chk("flag", wdogIrqFlag, 1'b0);
        waitFor(1'b1, 1'b1, 400);
        wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_TIMEOUT, swd_pkg::NWP_8));
        bounce(100);
        rd(swd_pkg::ADDR_MAIN_STATUS, 8'hFF, st(1'b1, swd_pkg::RSS_WD_OVERFLOW));
        rd(swd_pkg::ADDR_WD_CTRL, 8'hFF, wc(swd_pkg::WMC_TIMEOUT, swd_pkg::NWP_RESET));
        wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_WINDOW, swd_pkg::NWP_128));
        wr(swd_pkg::ADDR_MODE_CTRL, {5'h00, swd_pkg::MC_NORMAL});
        rd(swd_pkg::ADDR_MAIN_STATUS, 8'hFF, st(1'b0, swd_pkg::RSS_WD_OVERFLOW));
        cyc(160);
        wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_WINDOW, swd_pkg::NWP_128));
        chk("resetOutN", resetOutN, 1'b1);
        wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_WINDOW, swd_pkg::NWP_128));
        bounce(300);
        rd(swd_pkg::ADDR_MAIN_STATUS, 8'hFF, st(1'b0, swd_pkg::RSS_WD_EARLY));
        wr(swd_pkg::ADDR_MODE_CTRL, {5'h00, swd_pkg::MC_NORMAL});
        wr(swd_pkg::ADDR_WD_CTRL, wc(swd_pkg::WMC_WINDOW, swd_pkg::NWP_128));
        bounce(100);
        rd(swd_pkg::ADDR_MAIN_STATUS, 8'hFF, st(1'b0, swd_pkg::RSS_ILLEGAL_WMC));
        wr(swd_pkg::ADDR_MODE_CTRL, {5'h00, swd_pkg::MC_SLEEP});
        bounce(700);
        rd(swd_pkg::ADDR_MAIN_STATUS, 8'hFF, st(1'b0, swd_pkg::RSS_WD_SLEEP));
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            @(negedge clk_sys);
            resetReqCode = 5'(8'h01 + seed[7:0] % 8'h0B);
            pulse(1'b0);
            bounce(20);
            rd(swd_pkg::ADDR_MAIN_STATUS, 8'hFF, st(1'b0, resetReqCode));
        end
        @(negedge clk_sys);
        swDevCfg = 1'b1;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(5);
        rd(swd_pkg::ADDR_WD_CTRL, 8'hFF, wc(swd_pkg::WMC_AUTO, swd_pkg::NWP_RESET));
        rd(swd_pkg::ADDR_WD_STATUS, 8'h0C, 8'h04);
        tally_and_finish();
    end
endmodule
`default_nettype wire
